// *** rtl/ddr_read_map.svh ***
`ifndef DDR_READ_MAP_SVH
`define DDR_READ_MAP_SVH

// ============================================================================
// Widths and sizes
`define DDR_DATA_W        36
`define DDR_ADDR_W        20
`define DDR_BURST_LEN     4
`define DDR_STORE_BURSTS  16
`define DDR_BURST_IDX_W   4
`define DDR_WORD_IDX_W    6

// ============================================================================
// Output width configuration codes
`define DDR_WIDTH_X9      2'h0
`define DDR_WIDTH_X18     2'h1
`define DDR_WIDTH_X36     2'h2

// ============================================================================
// Lane masks for each configuration
`define DDR_MASK_X9       36'h0000001FF
`define DDR_MASK_X18      36'h00003FFFF
`define DDR_MASK_X36      36'hFFFFFFFFF

// ============================================================================
// Reset values
`define DDR_DATA_RESET    36'h000000000
`define DDR_ADDR_RESET    20'h00000

`endif

// *** rtl/ddr_read_pkg.sv ***
`include "ddr_read_map.svh"

package ddr_read_pkg;

  typedef logic [`DDR_DATA_W-1:0]      data_word_t;
  typedef logic [`DDR_ADDR_W-1:0]      addr_t;
  typedef logic [`DDR_WORD_IDX_W-1:0]  word_idx_t;
  typedef logic [`DDR_BURST_IDX_W-1:0] burst_idx_t;
  typedef logic [1:0]                  width_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_BEAT01 = 3'h2,
    ST_BEAT23 = 3'h4
  } read_state_t;

endpackage

// *** rtl/burst_store.sv ***
`include "ddr_read_map.svh"

module burst_store
  import ddr_read_pkg::*;
(
  input  wire logic                                clk_i,
  input  wire logic                                we_i,
  input  wire ddr_read_pkg::word_idx_t             windex_i,
  input  wire ddr_read_pkg::data_word_t            wdata_i,
  input  wire ddr_read_pkg::burst_idx_t            rburst_i,
  output logic [`DDR_BURST_LEN-1:0][`DDR_DATA_W-1:0] rwords_o
);

  // ==========================================================================
  // Storage
  // Array contents carry no reset; only control state needs a defined value.
  data_word_t mem [`DDR_STORE_BURSTS*`DDR_BURST_LEN];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[windex_i] <= wdata_i;
    end
  end

  // ==========================================================================
  // Burst read: four consecutive words of one burst slot.
  for (genvar w = 0; w < `DDR_BURST_LEN; w++) begin : g_rd
    assign rwords_o[w] = mem[{rburst_i, 2'(w)}];
  end

endmodule

// *** rtl/ddr_sram_read_port.sv ***
`include "ddr_read_map.svh"

module ddr_sram_read_port
  import ddr_read_pkg::*;
(
  input  wire logic                     clock_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     load_valid_i,
  output logic                          load_ready_o,
  input  wire ddr_read_pkg::word_idx_t  load_index_i,
  input  wire ddr_read_pkg::data_word_t load_word_i,
  input  wire ddr_read_pkg::width_sel_t width_sel_i,
  input  wire logic                     single_clock_mode_i,
  input  wire logic                     in_strobe_p_i,
  input  wire logic                     in_strobe_n_i,
  input  wire logic                     out_strobe_p_i,
  input  wire logic                     out_strobe_n_i,
  input  wire logic                     read_port_select_n_i,
  input  wire logic                     write_port_select_n_i,
  input  wire ddr_read_pkg::addr_t      shared_addr_bus_i,
  output ddr_read_pkg::data_word_t      read_data_p_o,
  output ddr_read_pkg::data_word_t      read_data_n_o,
  output logic                          read_data_oe_n_p_o,
  output logic                          read_data_oe_n_n_o,
  output logic                          mirror_strobe_p_o,
  output logic                          mirror_strobe_n_o,
  output logic                          write_req_o,
  output ddr_read_pkg::addr_t           write_addr_o
);

  import ddr_read_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic data_word_t lane_mask(input width_sel_t sel);
    case (sel)
      `DDR_WIDTH_X9:  lane_mask = `DDR_MASK_X9;
      `DDR_WIDTH_X18: lane_mask = `DDR_MASK_X18;
      default:        lane_mask = `DDR_MASK_X36;
    endcase
  endfunction

  // ==========================================================================
  // Launch clock selection
  // The mode pin is a strap: switching it while clocks run makes runt pulses.
  wire launch_clk_p = single_clock_mode_i ? in_strobe_p_i : out_strobe_p_i;
  wire launch_clk_n = single_clock_mode_i ? in_strobe_n_i : out_strobe_n_i;

  // Echo clocks are forwarded edges of the launch pair, so they share its
  // insertion delay and track the data across board flight time.
  assign mirror_strobe_p_o = launch_clk_p;
  assign mirror_strobe_n_o = launch_clk_n;

  // ==========================================================================
  // Core domain: load port crossing toward the input-p domain
  word_idx_t  hold_index;
  data_word_t hold_word;
  logic       req_tog;
  logic [2:0] ack_sync;
  logic       ack_tog;

  wire load_take = load_valid_i & load_ready_o;
  wire ack_edge  = ack_sync[1] ^ ack_sync[2];

  always_ff @(posedge clock_i) begin
    ack_sync <= {ack_sync[1:0], ack_tog};
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      load_ready_o <= 1'b1;
      req_tog      <= 1'b0;
      hold_index   <= '0;
      hold_word    <= `DDR_DATA_RESET;
    end else if (load_take) begin
      load_ready_o <= 1'b0;
      req_tog      <= ~req_tog;
      hold_index   <= load_index_i;
      hold_word    <= load_word_i;
    end else if (ack_edge) begin
      load_ready_o <= 1'b1;
    end
  end

  // ==========================================================================
  // Input-p domain: reset, strap and load synchronisers
  logic [1:0] k_rst_sync;
  logic [2:0] req_sync;
  width_sel_t width_meta;
  width_sel_t width_sync;

  always_ff @(posedge in_strobe_p_i) begin
    k_rst_sync <= {k_rst_sync[0], rst_n_i};
    req_sync   <= {req_sync[1:0], req_tog};
    width_meta <= width_sel_i;
    width_sync <= width_meta;
  end

  wire k_rst_n   = k_rst_sync[1];
  wire load_edge = req_sync[1] ^ req_sync[2];

  always_ff @(posedge in_strobe_p_i) begin
    if (!k_rst_n) begin
      ack_tog <= 1'b0;
    end else if (load_edge) begin
      ack_tog <= ~ack_tog;
    end
  end

  // ==========================================================================
  // Input-p domain: storage
  logic [`DDR_BURST_LEN-1:0][`DDR_DATA_W-1:0] rwords;

  // Only the low address bits reach storage; higher bits alias.
  wire burst_idx_t read_burst = shared_addr_bus_i[`DDR_BURST_IDX_W-1:0];

  burst_store u_store (
    .clk_i    (in_strobe_p_i),
    .we_i     (load_edge & k_rst_n),
    .windex_i (hold_index),
    .wdata_i  (hold_word),
    .rburst_i (read_burst),
    .rwords_o (rwords)
  );

  // ==========================================================================
  // Input-p domain: read sequencer
  read_state_t state;
  read_state_t next_state;
  data_word_t  pair_even;
  data_word_t  pair_odd;
  data_word_t  tail_even;
  data_word_t  tail_odd;
  logic        write_pending;

  wire        read_sel  = ~read_port_select_n_i;
  wire        can_start = (state == ST_IDLE) || (state == ST_BEAT23);
  wire        accept    = read_sel & can_start;
  wire        k_busy    = (state != ST_IDLE);
  wire data_word_t mask = lane_mask(width_sync);

  always_comb begin
    case (state)
      ST_IDLE:   next_state = accept ? ST_BEAT01 : ST_IDLE;
      ST_BEAT01: next_state = ST_BEAT23;
      // Deselection lets the running burst end, then the port goes idle.
      ST_BEAT23: next_state = accept ? ST_BEAT01 : ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge in_strobe_p_i) begin
    if (!k_rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // A select that arrives mid-burst is not queued; one read per two cycles.
  always_ff @(posedge in_strobe_p_i) begin
    if (!k_rst_n) begin
      pair_even <= `DDR_DATA_RESET;
      pair_odd  <= `DDR_DATA_RESET;
      tail_even <= `DDR_DATA_RESET;
      tail_odd  <= `DDR_DATA_RESET;
    end else if (accept) begin
      pair_even <= rwords[0] & mask;
      pair_odd  <= rwords[1] & mask;
      tail_even <= rwords[2] & mask;
      tail_odd  <= rwords[3] & mask;
    end else if (state == ST_BEAT01) begin
      pair_even <= tail_even;
      pair_odd  <= tail_odd;
    end
  end

  // In single clock mode the p launch flop shares the input-p edge, so even
  // beats leave one cycle later; odd beats take this one-cycle-late copy to
  // stay in step with them.
  data_word_t lag_odd;

  always_ff @(posedge in_strobe_p_i) begin
    if (!k_rst_n) begin
      lag_odd <= `DDR_DATA_RESET;
    end else begin
      lag_odd <= pair_odd;
    end
  end

  wire data_word_t odd_src = single_clock_mode_i ? lag_odd : pair_odd;

  // Write select is taken on the p edge; its address follows on the n edge.
  always_ff @(posedge in_strobe_p_i) begin
    if (!k_rst_n) begin
      write_pending <= 1'b0;
    end else begin
      write_pending <= ~write_port_select_n_i;
    end
  end

  // ==========================================================================
  // Input-n domain: write address capture
  logic [1:0] kn_rst_sync;

  always_ff @(posedge in_strobe_n_i) begin
    kn_rst_sync <= {kn_rst_sync[0], rst_n_i};
  end

  always_ff @(posedge in_strobe_n_i) begin
    if (!kn_rst_sync[1]) begin
      write_req_o  <= 1'b0;
      write_addr_o <= `DDR_ADDR_RESET;
    end else begin
      write_req_o <= write_pending;
      if (write_pending) begin
        write_addr_o <= shared_addr_bus_i;
      end
    end
  end

  // ==========================================================================
  // Launch-p domain: even transfers
  // The launch pair is mesochronous with input-p, so the pair registers,
  // which hold for a full input cycle, are sampled directly.
  logic [1:0] cp_rst_sync;

  always_ff @(posedge launch_clk_p) begin
    cp_rst_sync <= {cp_rst_sync[0], rst_n_i};
  end

  always_ff @(posedge launch_clk_p) begin
    if (!cp_rst_sync[1]) begin
      read_data_p_o      <= `DDR_DATA_RESET;
      read_data_oe_n_p_o <= 1'b1;
    end else begin
      read_data_p_o      <= k_busy ? pair_even : `DDR_DATA_RESET;
      read_data_oe_n_p_o <= ~k_busy;
    end
  end

  // ==========================================================================
  // Launch-n domain: odd transfers
  logic [1:0] cn_rst_sync;

  always_ff @(posedge launch_clk_n) begin
    cn_rst_sync <= {cn_rst_sync[0], rst_n_i};
  end

  always_ff @(posedge launch_clk_n) begin
    if (!cn_rst_sync[1]) begin
      read_data_n_o      <= `DDR_DATA_RESET;
      read_data_oe_n_n_o <= 1'b1;
    end else begin
      read_data_n_o      <= read_data_oe_n_p_o ? `DDR_DATA_RESET : odd_src;
      read_data_oe_n_n_o <= read_data_oe_n_p_o;
    end
  end

endmodule

// *** bench/ddr_read_checker.sv ***
`include "ddr_read_map.svh"

module ddr_read_checker
  import ddr_read_pkg::*;
(
  input wire logic                     clock_i,
  input wire logic                     rst_n_i,
  input wire ddr_read_pkg::width_sel_t width_sel_i,
  input wire logic                     single_clock_mode_i,
  input wire logic                     in_strobe_p_i,
  input wire logic                     in_strobe_n_i,
  input wire logic                     out_strobe_p_i,
  input wire logic                     out_strobe_n_i,
  input wire logic                     read_port_select_n_i,
  input wire logic                     write_port_select_n_i,
  input wire ddr_read_pkg::data_word_t read_data_p_o,
  input wire logic                     read_data_oe_n_p_o,
  input wire logic                     read_data_oe_n_n_o,
  input wire logic                     mirror_strobe_p_o,
  input wire logic                     mirror_strobe_n_o,
  input wire logic                     write_req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Pin relations, sampled where both sides are settled.
  a_mirror_p_src: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mirror_strobe_p_o == (single_clock_mode_i ? in_strobe_p_i : out_strobe_p_i))
    else $error("mirror p wrong source");
  a_mirror_n_src: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mirror_strobe_n_o == (single_clock_mode_i ? in_strobe_n_i : out_strobe_n_i))
    else $error("mirror n wrong source");
  a_idle_data_zero: assert property (@(posedge in_strobe_p_i) disable iff (!rst_n_i)
    read_data_oe_n_p_o |-> read_data_p_o == '0) else $error("data while idle");
  a_width_mask_x9: assert property (@(posedge in_strobe_p_i) disable iff (!rst_n_i)
    !read_data_oe_n_p_o && width_sel_i == `DDR_WIDTH_X9 |-> (read_data_p_o & ~`DDR_MASK_X9) == '0)
    else $error("lanes beyond x9 driven");
  a_read_drives_two: assert property (@(posedge in_strobe_p_i) disable iff (!rst_n_i)
    !single_clock_mode_i && !read_port_select_n_i && $past(read_port_select_n_i)
    |=> !read_data_oe_n_p_o [*2]) else $error("read burst not driven");
  a_release_p_side: assert property (@(posedge in_strobe_p_i) disable iff (!rst_n_i)
    !single_clock_mode_i && read_port_select_n_i && $past(read_port_select_n_i)
    |=> read_data_oe_n_p_o) else $error("p side still driven");
  a_release_n_side: assert property (@(posedge in_strobe_p_i) disable iff (!rst_n_i)
    !single_clock_mode_i && read_port_select_n_i && $past(read_port_select_n_i)
    |=> read_data_oe_n_n_o) else $error("n side still driven");
  a_write_req_follow: assert property (@(posedge in_strobe_p_i) disable iff (!rst_n_i)
    1'b1 |=> write_req_o == !$past(write_port_select_n_i)) else $error("write request off");
endmodule

bind ddr_sram_read_port ddr_read_checker chk_u (.*);

// *** bench/ctrl_model.sv ***
module ctrl_model
  import ddr_read_pkg::*;
(
  input  wire logic                rd_req_i,
  input  wire logic                wr_req_i,
  input  wire logic [3:0]          slot_i,
  input  wire ddr_read_pkg::addr_t wr_addr_i,
  output logic                     in_p_o,
  output logic                     in_n_o,
  output logic                     out_p_o,
  output logic                     out_n_o,
  output logic                     sel_n_o,
  output logic                     wsel_n_o,
  output ddr_read_pkg::addr_t      addr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Clocks run free; the output pair lags by a board flight time.
  initial begin
    {in_p_o, in_n_o, sel_n_o, wsel_n_o, addr_o} = {4'h7, 20'h00000};
    #2.5;
    forever #15 {in_p_o, in_n_o} = ~{in_p_o, in_n_o};
  end
  assign #3 {out_p_o, out_n_o} = {in_p_o, in_n_o};
  // An unused address slot toggles so a stale value is never mistaken for a match.
  always @(posedge in_p_o) begin
    sel_n_o  <= #1 !rd_req_i;
    wsel_n_o <= #1 !wr_req_i;
    addr_o   <= #1 !wsel_n_o ? wr_addr_i : ~addr_o;
  end
  always @(posedge in_n_o) addr_o <= #1 !sel_n_o ? {16'h0000, slot_i} : ~addr_o;
endmodule

// *** bench/tb.sv ***
`include "ddr_read_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ddr_read_pkg::*;
  logic       clock_i, rst_n_i, load_valid_i, load_ready_o, single_clock_mode_i;
  logic       in_strobe_p_i, in_strobe_n_i, out_strobe_p_i, out_strobe_n_i;
  logic       read_port_select_n_i, write_port_select_n_i, write_req_o, rd_req, wr_req;
  logic       read_data_oe_n_p_o, read_data_oe_n_n_o, mirror_strobe_p_o, mirror_strobe_n_o;
  logic [3:0] slot;
  word_idx_t  load_index_i;
  data_word_t load_word_i, read_data_p_o, read_data_n_o;
  width_sel_t width_sel_i;
  addr_t      shared_addr_bus_i, write_addr_o, wr_addr;
  int         bad_count, comparisons;
  wire [`DDR_DATA_W-1:0] pad;
  ddr_sram_read_port dut_u (.*);
  ctrl_model ctl_u (.rd_req_i(rd_req), .wr_req_i(wr_req), .slot_i(slot), .wr_addr_i(wr_addr),
    .in_p_o(in_strobe_p_i), .in_n_o(in_strobe_n_i), .out_p_o(out_strobe_p_i),
    .out_n_o(out_strobe_n_i), .sel_n_o(read_port_select_n_i),
    .wsel_n_o(write_port_select_n_i), .addr_o(shared_addr_bus_i));
  // ==========================================================================
  // The board pad: each half clock carries one beat, p or n word, and it floats when undriven.
  assign pad = (!read_data_oe_n_p_o && mirror_strobe_p_o) ? read_data_p_o :
               (!read_data_oe_n_n_o && mirror_strobe_n_o) ? read_data_n_o : 'z;
  always #4 clock_i = ~clock_i;
  function automatic data_word_t word_of(input word_idx_t i);
    return {i, 30'h15555555 ^ {24'h000000, i}};
  endfunction
  task automatic cmp(input data_word_t got, input data_word_t exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic load(input word_idx_t i);
    int n;
    n = 0;
    while (load_ready_o !== 1'b1) begin
      @(posedge clock_i);
      #1 n++;
      if (n > 100) begin
        bad_count++;
        $display("BAD %0t load never ready", $time);
        close_out;
      end
    end
    {load_index_i, load_word_i, load_valid_i} = {i, word_of(i), 1'b1};
    @(posedge clock_i);
    #1 load_valid_i = 1'b0;
  endtask
  // Capture follows the mirror strobes, which absorbs flight time on the return path.
  task automatic beats(input logic [3:0] s, input data_word_t mask);
    for (int b = 0; b < 4; b++) begin
      if (b[0]) @(posedge mirror_strobe_n_o);
      else @(posedge mirror_strobe_p_o);
      #2 cmp(pad, word_of({s, b[1:0]}) & mask);
    end
  endtask
  task automatic reads(input logic [2:0] pat, input logic [3:0] sa, input logic [3:0] sb,
                       input data_word_t mask);
    fork
      begin
        for (int k = 0; k < 4; k++) begin
          @(posedge in_strobe_p_i);
          #1 {rd_req, slot} = {k < 3 && pat[k], k < 2 ? sa : sb};
        end
      end
      begin
        repeat (3) @(posedge in_strobe_p_i);
        #1 beats(sa, mask);
        if (pat[2]) beats(sb, mask);
        @(posedge mirror_strobe_p_o);
        #2 cmp(pad, 'z);
      end
    join
  endtask
  task automatic t_read;
    reads(3'b001, 4'h2, 4'h2, `DDR_MASK_X36);
    $display("single read done");
  endtask
  task automatic t_gapless;
    reads(3'b101, 4'h0, 4'h1, `DDR_MASK_X36);
    $display("gapless reads done");
  endtask
  task automatic t_refused;
    reads(3'b011, 4'h3, 4'h3, `DDR_MASK_X36);
    $display("mid burst select done");
  endtask
  task automatic t_write;
    @(posedge in_strobe_p_i);
    #1 {wr_req, wr_addr} = {1'b1, 20'hA5C3E};
    @(posedge in_strobe_p_i);
    #1 wr_req = 1'b0;
    @(posedge in_strobe_p_i);
    @(posedge in_strobe_n_i);
    #2 cmp({15'h0000, write_req_o, write_addr_o}, {16'h0001, 20'hA5C3E});
    $display("write address done");
  endtask
  task automatic t_narrow;
    @(posedge in_strobe_p_i);
    #1 width_sel_i = `DDR_WIDTH_X9;
    repeat (4) @(posedge in_strobe_p_i);
    reads(3'b001, 4'h1, 4'h1, `DDR_MASK_X9);
    $display("narrow read done");
  endtask
  task automatic t_one_clock;
    @(posedge in_strobe_p_i);
    #1 single_clock_mode_i = 1'b1;
    repeat (2) @(posedge in_strobe_p_i);
    reads(3'b001, 4'h3, 4'h3, `DDR_MASK_X9);
    $display("single clock read done");
  endtask
  initial begin
    {clock_i, rst_n_i, load_valid_i, single_clock_mode_i, rd_req, wr_req} = 6'h00;
    {load_index_i, load_word_i, slot, wr_addr} = '0;
    width_sel_i = `DDR_WIDTH_X36;
    bad_count = 0;
    comparisons = 0;
    // Four input-strobe cycles, so every clock domain's reset stage clears.
    repeat (16) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge in_strobe_p_i);
    @(posedge clock_i);
    #1 for (int i = 0; i < 16; i++) load(i[5:0]);
    t_read;
    t_gapless;
    t_refused;
    t_write;
    t_narrow;
    t_one_clock;
    close_out;
  end
endmodule
